// File: common/mpel_pkg.sv
// Purpose: constants, register map and carrier types for the meter pulse and event logic
// Assumes: 50 MHz pclk, 4000 Hz sample rate, 24-bit fractional measurements (1.0 = 2^23)
// Notes: register offsets are byte addresses on a 32-bit APB slave
package mpel_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_NS = 20;
    localparam int OWR_HZ = 4000;
    localparam int SAMPLE_DIV = CLK_HZ / OWR_HZ;
    localparam int PULSE_BASE_NS = 250_000;
    localparam int PULSE_BASE_CYC = (PULSE_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PW_DIV = 64000;
    localparam int TEMP_PERIOD = 2240;
    localparam int FRAC_BITS = 23;
    localparam logic [4:0] PS_START_CODE = 5'h16;
    localparam logic [48:0] ONE_PULSE = 49'h0_4000_0000_0000;

    localparam logic [7:0] A_CFG = 8'h00;
    localparam logic [7:0] A_PCTL = 8'h04;
    localparam logic [7:0] A_RATE = 8'h08;
    localparam logic [7:0] A_LOWT = 8'h0C;
    localparam logic [7:0] A_RNG = 8'h10;
    localparam logic [7:0] A_FIX = 8'h14;
    localparam logic [7:0] A_NOLOAD = 8'h18;
    localparam logic [7:0] A_CHMIN = 8'h1C;
    localparam logic [7:0] A_CHLVL = 8'h20;
    localparam logic [7:0] A_STATUS = 8'h24;
    localparam logic [7:0] A_PSEQ = 8'h28;
    localparam logic [7:0] A_TOTP = 8'h2C;
    localparam logic [7:0] A_TOTQ = 8'h30;
    localparam logic [7:0] A_TOTS = 8'h34;
    localparam logic [7:0] A_TEMP = 8'h38;
    localparam logic [3:0] A_DUR_HI = 4'h4;
    localparam logic [3:0] A_LVL_HI = 4'h5;

    localparam logic [23:0] RST_LOW_TIME = 24'h00_0001;
    localparam logic [23:0] RST_FIXED_RMS = 24'h5A_8279;
    localparam logic [23:0] RST_CH_LEVEL = 24'h02_8F5C;

    typedef struct packed {
        logic [23:0] v;
        logic [23:0] i1;
        logic [23:0] i2;
        logic [1:0][23:0] pwr_p;
        logic [1:0][23:0] pwr_q;
        logic [1:0][23:0] pwr_s;
        logic [1:0][23:0] irms;
        logic [23:0] temp;
    } mpel_meas_t;

    typedef struct packed {
        logic [15:0] div_cnt;
        logic tick;
        logic hold;
        logic forced_ch;
        logic fixed_voltage_select;
        logic ivsp;
        logic [2:0] gen_on;
        logic [2:0][3:0] in_sel;
        logic [2:0][3:0] pin_src;
        logic [23:0] rate;
        logic [23:0] low_time;
        logic [3:0] rng;
        logic [23:0] fixed_rms;
        logic [23:0] no_load;
        logic [23:0] ch_min;
        logic [23:0] ch_level;
        logic [3:0][15:0] dur;
        logic [3:0][23:0] level;
        logic [3:0][15:0] win_cnt;
        logic [3:0][15:0] above;
        logic [3:0][15:0] below;
        logic [3:0] win_end;
        logic [3:0] evt_flag;
        logic temp_flag;
        logic [11:0] temp_cnt;
        logic [23:0] temperature;
        logic active_ch;
        logic [23:0] tot_p;
        logic [23:0] tot_q;
        logic [23:0] tot_s;
        logic [2:0][48:0] acc;
        logic [2:0][35:0] low_cnt;
        logic [2:0] pin_out;
        logic [2:0] pin_oe;
        logic ps_dir;
        logic ps_run;
        logic ps_done;
        logic [6:0] ps_cnt;
        logic v_neg_prev;
        logic [31:0] rdata;
    } mpel_state_t;
endpackage

// File: src/mpel_core.sv
// Purpose: energy pulse generators, sag/swell/overcurrent voting, phase sequence, temperature timing, anti-creep
// Assumes: measurement inputs come from logic on pclk and are valid whenever sampled on the tick
// Notes: sample processing advances on a one-cycle sample tick divided down from pclk; pulse low counters and pins update every pclk
`timescale 1ns/10ps
module mpel_core
    import mpel_pkg::*;
#(
    parameter int SAMPLE_DIV_P = SAMPLE_DIV,
    parameter int PULSE_BASE_P = PULSE_BASE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mpel_meas_t meas,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe
);
    mpel_state_t s;
    mpel_state_t next_s;
    logic addr_ok;
    logic [31:0] rd_val;
    logic wr_en;
    logic ps_start;
    logic [35:0] low_cyc;
    logic [1:0][23:0] p_eff;
    logic [23:0] cur_p;
    logic [23:0] cur_q;
    logic [23:0] cur_s;
    logic [23:0] m1;
    logic [23:0] m2;
    logic [23:0] pw_in;
    logic [47:0] prod;
    logic [48:0] sum;
    logic [23:0] smp;
    logic [15:0] ab_n;
    logic [15:0] be_n;
    logic zx;

    function automatic logic [23:0] mag24(input logic [23:0] x);
        return x[23] ? 24'(-x) : x;
    endfunction

    // true when a exceeds b by more than the hysteresis fraction of b
    function automatic logic beats(input logic [23:0] a, input logic [23:0] b, input logic [23:0] lvl);
        logic [47:0] h;
        h = 48'(b) * 48'(lvl);
        return {1'b0, a} > ({1'b0, b} + h[47:23]);
    endfunction

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = s.rdata;
    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign ps_start = wr_en && (paddr == A_PSEQ) && (pwdata[4:0] == PS_START_CODE);
    assign low_cyc = 36'(PULSE_BASE_P) + 36'((56'(s.low_time) * 56'(CLK_HZ)) / 56'(PW_DIV));

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        next_s.win_end = 4'h0;
        addr_ok = 1'b1;
        rd_val = 32'h0000_0000;
        prod = 48'h0000_0000_0000;
        sum = 49'h0_0000_0000_0000;
        pw_in = 24'h00_0000;
        smp = 24'h00_0000;
        ab_n = 16'h0000;
        be_n = 16'h0000;
        zx = 1'b0;

        // sample tick divider
        if (s.div_cnt == 16'(SAMPLE_DIV_P - 1)) begin
            next_s.div_cnt = 16'h0000;
            next_s.tick = 1'b1;
        end else begin
            next_s.div_cnt = s.div_cnt + 16'h0001;
        end

        // register read decode
        if (paddr[7:4] == A_DUR_HI && paddr[1:0] == 2'b00) begin
            rd_val = {16'h0000, s.dur[paddr[3:2]]};
        end else if (paddr[7:4] == A_LVL_HI && paddr[1:0] == 2'b00) begin
            rd_val = {8'h00, s.level[paddr[3:2]]};
        end else begin
            case (paddr)
                A_CFG: rd_val = {25'h000_0000, s.gen_on, s.ivsp, s.fixed_voltage_select, s.forced_ch, s.hold};
                A_PCTL: rd_val = {8'h00, s.pin_src, s.in_sel};
                A_RATE: rd_val = {8'h00, s.rate};
                A_LOWT: rd_val = {8'h00, s.low_time};
                A_RNG: rd_val = {28'h000_0000, s.rng};
                A_FIX: rd_val = {8'h00, s.fixed_rms};
                A_NOLOAD: rd_val = {8'h00, s.no_load};
                A_CHMIN: rd_val = {8'h00, s.ch_min};
                A_CHLVL: rd_val = {8'h00, s.ch_level};
                A_STATUS: rd_val = {26'h000_0000, s.active_ch, s.temp_flag, s.evt_flag};
                A_PSEQ: rd_val = {18'h0_0000, s.ps_cnt, s.ps_done, s.ps_dir, 5'h00};
                A_TOTP: rd_val = {8'h00, s.tot_p};
                A_TOTQ: rd_val = {8'h00, s.tot_q};
                A_TOTS: rd_val = {8'h00, s.tot_s};
                A_TEMP: rd_val = {8'h00, s.temperature};
                default: addr_ok = 1'b0;
            endcase
        end
        if (psel && !penable) begin
            next_s.rdata = addr_ok ? rd_val : 32'h0000_0000;
        end

        // register writes; hardware events below take priority over clears
        if (wr_en) begin
            if (paddr[7:4] == A_DUR_HI) begin
                next_s.dur[paddr[3:2]] = pwdata[15:0];
            end else if (paddr[7:4] == A_LVL_HI) begin
                next_s.level[paddr[3:2]] = pwdata[23:0];
            end else begin
                case (paddr)
                    A_CFG: begin
                        next_s.hold = pwdata[0];
                        next_s.forced_ch = pwdata[1];
                        next_s.fixed_voltage_select = pwdata[2];
                        next_s.ivsp = pwdata[3];
                        next_s.gen_on = pwdata[6:4];
                    end
                    A_PCTL: begin
                        next_s.in_sel = pwdata[11:0];
                        next_s.pin_src = pwdata[23:12];
                    end
                    A_RATE: next_s.rate = pwdata[23:0];
                    A_LOWT: next_s.low_time = pwdata[23:0];
                    A_RNG: next_s.rng = pwdata[3:0];
                    A_FIX: next_s.fixed_rms = pwdata[23:0];
                    A_NOLOAD: next_s.no_load = pwdata[23:0];
                    A_CHMIN: next_s.ch_min = pwdata[23:0];
                    A_CHLVL: next_s.ch_level = pwdata[23:0];
                    A_STATUS: begin
                        next_s.evt_flag = s.evt_flag & ~pwdata[3:0];
                        next_s.temp_flag = s.temp_flag & ~pwdata[4];
                    end
                    A_PSEQ: begin
                        next_s.ps_dir = pwdata[5];
                        if (ps_start) begin
                            next_s.ps_run = 1'b1;
                            next_s.ps_done = 1'b0;
                            next_s.ps_cnt = 7'h00;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // channel selection
        m1 = s.ivsp ? meas.irms[0] : mag24(meas.pwr_p[0]);
        m2 = s.ivsp ? meas.irms[1] : mag24(meas.pwr_p[1]);
        if (s.tick) begin
            if (s.hold) begin
                next_s.active_ch = s.forced_ch;
            end else if (m1 > s.ch_min || m2 > s.ch_min) begin
                if (!s.active_ch && beats(m2, m1, s.ch_level)) begin
                    next_s.active_ch = 1'b1;
                end else if (s.active_ch && beats(m1, m2, s.ch_level)) begin
                    next_s.active_ch = 1'b0;
                end
            end
        end

        // active power with optional fixed voltage, then totals with anti-creep
        for (int c = 0; c < 2; c++) begin
            prod = 48'(s.fixed_rms) * 48'(meas.irms[c]);
            p_eff[c] = s.fixed_voltage_select ? prod[46:23] : meas.pwr_p[c];
        end
        cur_p = p_eff[s.active_ch];
        cur_q = meas.pwr_q[s.active_ch];
        cur_s = meas.pwr_s[s.active_ch];
        if (s.tick) begin
            if (mag24(cur_p) < s.no_load && mag24(cur_q) < s.no_load) begin
                next_s.tot_p = 24'h00_0000;
                next_s.tot_q = 24'h00_0000;
            end else begin
                next_s.tot_p = cur_p;
                next_s.tot_q = cur_q;
            end
            next_s.tot_s = (mag24(cur_s) < s.no_load) ? 24'h00_0000 : cur_s;
        end

        // pulse generators
        for (int g = 0; g < 3; g++) begin
            case (s.in_sel[g])
                4'h0: pw_in = s.tot_p;
                4'h1: pw_in = s.tot_q;
                4'h2: pw_in = s.tot_s;
                4'h3: pw_in = p_eff[0];
                4'h4: pw_in = p_eff[1];
                4'h5: pw_in = meas.pwr_q[0];
                4'h6: pw_in = meas.pwr_q[1];
                4'h7: pw_in = meas.pwr_s[0];
                4'h8: pw_in = meas.pwr_s[1];
                default: pw_in = 24'h00_0000;
            endcase
            if (!s.gen_on[g]) begin
                next_s.acc[g] = 49'h0_0000_0000_0000;
                next_s.low_cnt[g] = 36'h0_0000_0000;
            end else begin
                if (s.low_cnt[g] != 36'h0_0000_0000) begin
                    next_s.low_cnt[g] = s.low_cnt[g] - 36'h0_0000_0001;
                end
                if (s.tick) begin
                    // per sample, add |P| * rate / 2^(range+1); one pulse per 2^46
                    prod = 48'(mag24(pw_in)) * 48'(s.rate);
                    sum = s.acc[g] + 49'(prod >> ({1'b0, s.rng} + 5'h01));
                    if (sum >= ONE_PULSE) begin
                        sum = sum - ONE_PULSE;
                        if (s.low_cnt[g] == 36'h0_0000_0000) begin
                            next_s.low_cnt[g] = low_cyc;
                        end
                    end
                    next_s.acc[g] = sum;
                end
            end
        end

        // output pin routing
        for (int p = 0; p < 3; p++) begin
            case (s.pin_src[p])
                4'h1, 4'h2, 4'h3: begin
                    next_s.pin_oe[p] = 1'b1;
                    next_s.pin_out[p] = (s.low_cnt[s.pin_src[p] - 4'h1] == 36'h0_0000_0000);
                end
                default: begin
                    next_s.pin_oe[p] = 1'b0;
                    next_s.pin_out[p] = 1'b1;
                end
            endcase
        end

        // sag, swell and overcurrent voting; 0 V sag, 1 V swell, 2 I1 over, 3 I2 over
        for (int d = 0; d < 4; d++) begin
            smp = (d < 2) ? meas.v : ((d == 2) ? meas.i1 : meas.i2);
            if (s.dur[d] == 16'h0000) begin
                next_s.win_cnt[d] = 16'h0000;
                next_s.above[d] = 16'h0000;
                next_s.below[d] = 16'h0000;
            end else if (s.tick) begin
                ab_n = s.above[d] + {15'h0000, mag24(smp) > s.level[d]};
                be_n = s.below[d] + {15'h0000, mag24(smp) < s.level[d]};
                if (s.win_cnt[d] >= s.dur[d] - 16'h0001) begin
                    next_s.win_end[d] = 1'b1;
                    next_s.win_cnt[d] = 16'h0000;
                    next_s.above[d] = 16'h0000;
                    next_s.below[d] = 16'h0000;
                    if (d == 0 && be_n > ab_n) begin
                        next_s.evt_flag[d] = 1'b1;
                    end else if (d != 0 && ab_n > be_n) begin
                        next_s.evt_flag[d] = 1'b1;
                    end
                end else begin
                    next_s.win_cnt[d] = s.win_cnt[d] + 16'h0001;
                    next_s.above[d] = ab_n;
                    next_s.below[d] = be_n;
                end
            end
        end

        // temperature update timer
        if (s.tick) begin
            if (s.temp_cnt == 12'(TEMP_PERIOD - 1)) begin
                next_s.temp_cnt = 12'h000;
                next_s.temperature = meas.temp;
                next_s.temp_flag = 1'b1;
            end else begin
                next_s.temp_cnt = s.temp_cnt + 12'h001;
            end
        end

        // phase sequence counter
        if (s.tick) begin
            next_s.v_neg_prev = meas.v[23];
            zx = s.ps_dir ? (!s.v_neg_prev && meas.v[23]) : (s.v_neg_prev && !meas.v[23]);
            if (s.ps_run && !ps_start) begin
                if (zx) begin
                    next_s.ps_run = 1'b0;
                    next_s.ps_done = 1'b1;
                end else if (s.ps_cnt != 7'h7F) begin
                    next_s.ps_cnt = s.ps_cnt + 7'h01;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.low_time <= RST_LOW_TIME;
            s.fixed_rms <= RST_FIXED_RMS;
            s.ch_level <= RST_CH_LEVEL;
            s.pin_out <= 3'b111;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // the divider count stays below its modulus, so the next tick is never late
    property p_tick_single;
        (s.tick |=> !s.tick && s.div_cnt == 16'h0001) and (s.div_cnt < 16'(SAMPLE_DIV_P));
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("sample tick not single or late");
    property p_hold_forces;
        s.tick && s.hold |=> s.active_ch == $past(s.forced_ch);
    endproperty
    a_hold_forces: assert property (p_hold_forces) else $error("held selection ignored forced channel");
    property p_gen_off;
        !s.gen_on[0] |=> s.low_cnt[0] == 36'h0_0000_0000 && s.acc[0] == 49'h0_0000_0000_0000;
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("disabled generator still active");
    property p_pin_hiz;
        s.pin_src[0] == 4'h0 |=> !s.pin_oe[0];
    endproperty
    a_pin_hiz: assert property (p_pin_hiz) else $error("unselected pin driven");
    property p_pulse_low;
        s.low_cnt[0] == 36'h0_0000_0000 ##1 s.low_cnt[0] != 36'h0_0000_0000 |-> s.low_cnt[0] == $past(low_cyc);
    endproperty
    a_pulse_low: assert property (p_pulse_low) else $error("pulse low time wrong");
    property p_dur_zero;
        s.dur[2] == 16'h0000 |=> s.win_cnt[2] == 16'h0000 && !s.win_end[2];
    endproperty
    a_dur_zero: assert property (p_dur_zero) else $error("detector ran with zero duration");
    property p_sag_cause;
        $rose(s.evt_flag[0]) |-> s.win_end[0];
    endproperty
    a_sag_cause: assert property (p_sag_cause) else $error("sag flag set outside window end");
    property p_swell_cause;
        $rose(s.evt_flag[1]) |-> s.win_end[1];
    endproperty
    a_swell_cause: assert property (p_swell_cause) else $error("swell flag set outside window end");
    property p_ps_start;
        ps_start |=> s.ps_run && !s.ps_done && s.ps_cnt == 7'h00;
    endproperty
    a_ps_start: assert property (p_ps_start) else $error("phase count did not start");
    property p_ps_done;
        $rose(s.ps_done) |-> !s.ps_run ##1 (s.ps_done && $stable(s.ps_cnt)) [*2];
    endproperty
    a_ps_done: assert property (p_ps_done) else $error("phase count not frozen at done");
    property p_temp;
        s.tick && s.temp_cnt == 12'(TEMP_PERIOD - 1) |=> s.temp_flag && s.temp_cnt == 12'h000;
    endproperty
    a_temp: assert property (p_temp) else $error("temperature update missed");
    property p_creep;
        s.tick && mag24(cur_p) < s.no_load && mag24(cur_q) < s.no_load |=>
            s.tot_p == 24'h00_0000 && s.tot_q == 24'h00_0000;
    endproperty
    a_creep: assert property (p_creep) else $error("no-load totals not zeroed");
    property p_creep_s;
        s.tick && mag24(cur_s) < s.no_load |=> s.tot_s == 24'h00_0000;
    endproperty
    a_creep_s: assert property (p_creep_s) else $error("no-load apparent not zeroed");
    c_pulse: cover property (s.pin_oe[0] && $fell(s.pin_out[0]));
    c_sag: cover property ($rose(s.evt_flag[0]));
    c_ps_done: cover property ($rose(s.ps_done));
    c_switch: cover property (!s.hold && $changed(s.active_ch));
endmodule

// File: sim/mpel_pulse_meter.sv
// Purpose: pulse-counting test equipment on the first output pin
// Assumes: pins have a pull-up, so a released pin reads high
// Notes: measures the last low time and the fall-to-fall period in pclk cycles
`timescale 1ns/10ps
module mpel_pulse_meter (
    input wire logic pclk,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    output logic [15:0] low_len,
    output logic [15:0] period
);
    logic [2:0] lvl;
    logic prev;
    logic [15:0] lo_cnt;
    logic [15:0] per_cnt;
    assign lvl = (pin_oe & pin_out) | ~pin_oe;
    initial begin
        prev = 1'b1;
        lo_cnt = 16'h0000;
        per_cnt = 16'h0000;
        low_len = 16'h0000;
        period = 16'h0000;
    end
    always @(posedge pclk) begin
        per_cnt <= per_cnt + 16'h0001;
        prev <= lvl[0];
        if (!lvl[0]) begin
            lo_cnt <= lo_cnt + 16'h0001;
        end
        if (prev && !lvl[0]) begin
            period <= per_cnt;
            per_cnt <= 16'h0001;
        end
        if (!prev && lvl[0]) begin
            low_len <= lo_cnt;
            lo_cnt <= 16'h0000;
        end
    end
endmodule

// File: sim/tb.sv
// Purpose: self-checking bench for the meter pulse and event logic
// Assumes: short tick (20 pclk) and short pulse base (10 pclk)
// Notes: registers reached by a zero-wait APB master that still waits for pready
`timescale 1ns/10ps
module tb;
    import mpel_pkg::*;
    localparam int TK = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr;
    logic [2:0] pin_out, pin_oe;
    logic [15:0] low_len, period;
    mpel_meas_t meas = '0;
    int err_total = 0, cmp_count = 0;
    mpel_core #(.SAMPLE_DIV_P(TK), .PULSE_BASE_P(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas(meas), .pin_out(pin_out), .pin_oe(pin_oe));
    mpel_pulse_meter meter (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .low_len(low_len), .period(period));
    initial begin
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // this wait ends at the first edge with pready high, or when the watchdog fires
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        chk(pslverr, (a > 8'h5C || a == 8'h3C) ? 1 : 0);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n * TK) @(posedge pclk);
    endtask
    task automatic t_reset_values();
        chk(pin_oe, 0);
        apb(0, A_PCTL, 0); chk(r, 0);
        apb(0, A_LOWT, 0); chk(r, 1);
        apb(0, A_FIX, 0); chk(r, RST_FIXED_RMS);
        apb(0, 8'h44, 0); chk(r, 0);
        apb(0, 8'h3C, 0); chk(r, 0);
    endtask
    task automatic t_detect();
        meas.v <= 24'h01_0000; meas.i1 <= 24'hD0_0000;
        apb(1, 8'h50, 32'h0010_0000); apb(1, 8'h58, 32'h0010_0000);
        apb(1, 8'h40, 4); apb(1, 8'h48, 4);
        ticks(12);
        apb(0, A_STATUS, 0); chk(r[3:0], 4'h5);
    endtask
    task automatic t_phase();
        meas.v <= 24'hF0_0000;
        ticks(2);
        apb(1, A_PSEQ, 32'h0000_0016);
        ticks(10);
        apb(0, A_PSEQ, 0); chk(r[6], 0);
        meas.v <= 24'h10_0000;
        ticks(80);
        apb(0, A_PSEQ, 0); chk(r[6], 1);
        chk(r[13:7] >= 9 && r[13:7] <= 12, 1);
        apb(1, A_PSEQ, 32'h0000_0036);
        ticks(5);
        apb(0, A_PSEQ, 0); chk(r[6], 0);
        meas.v <= 24'hF0_0000;
        ticks(80);
        apb(0, A_PSEQ, 0); chk(r[6], 1);
        chk(r[13:7] >= 4 && r[13:7] <= 7, 1);
    endtask
    task automatic t_totals();
        apb(1, A_CFG, 1);
        meas.pwr_p <= {24'h00_0200, 24'h00_0100}; meas.pwr_q <= {2{24'h00_0100}};
        meas.pwr_s <= {2{24'h00_0100}};
        apb(1, A_NOLOAD, 32'h0000_1000); ticks(3);
        apb(0, A_TOTP, 0); chk(r, 0);
        apb(0, A_TOTS, 0); chk(r, 0);
        apb(1, A_NOLOAD, 0); ticks(3);
        apb(0, A_TOTP, 0); chk(r, 32'h0000_0100);
        apb(1, A_CFG, 3); ticks(3);
        apb(0, A_TOTP, 0); chk(r, 32'h0000_0200);
        meas.irms <= {24'h00_0000, 24'h80_0000};
        apb(1, A_CFG, 5); ticks(3);
        apb(0, A_TOTP, 0); chk(r, {8'h00, RST_FIXED_RMS});
        apb(0, A_TOTQ, 0); chk(r, 32'h0000_0100);
    endtask
    task automatic t_pulse();
        meas.pwr_p <= {24'h40_0000, 24'h00_0100};
        apb(1, A_RATE, 32'h0040_0000); apb(1, A_LOWT, 0); apb(1, A_RNG, 0);
        apb(1, A_PCTL, 32'h0000_1000);
        ticks(20); chk(pin_oe, 3'b001); chk(low_len, 0);
        apb(1, A_CFG, 32'h0000_0013); ticks(40);
        chk(period, 8 * TK);
        chk(low_len, 10);
        chk(pin_oe, 3'b001);
    endtask
    task automatic t_temp();
        meas.temp <= 24'h12_3456;
        ticks(TEMP_PERIOD);
        apb(0, A_STATUS, 0); chk(r[4], 1);
        apb(0, A_TEMP, 0); chk(r, 32'h0012_3456);
        apb(1, A_STATUS, 32'h0000_0010);
        apb(0, A_STATUS, 0); chk(r[4], 0);
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #1_200_000;
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_detect();
        t_phase();
        t_totals();
        t_pulse();
        t_temp();
        give_verdict();
    end
endmodule
